/* design/fpec_ctrl.sv */
/*
  Flash program/erase control: control and block select registers behind an AXI4-Lite slave,
  write gating by the hardware write pin and software gate, and the erase permit check.
  Assumes the hardware write pin and standby request are synchronous to core_clk_i and
  that the flash array samples the mode outputs directly.
*/
// Overview of operation
// (R01) Burn setup resets 0; set only with pin high and software gate 1.
// (R02) Clear check resets 0; settable when gated, writing 0 leaves it.
// (R03) Burn check resets 0; settable when gated, clearing it exits.
// (R04) Erase run settable only when gated and clear setup already 1.
// (R05) Burn run settable only when gated and burn setup already 1.
// (R06) Software changes at most one mode control bit per write.
// (R07) Software toggles the software gate in a write of its own.
// (R08) Software should arm the watchdog before starting a burn or erase run.
// (R09) Block select clears on reset, standby, pin low, or gate 0.
// (R10) Block n erasable only when its select bit is 1.
// (R11) Block select bits cannot be set while the software gate is 0.
// (R12) Software selects only one erase block at a time.
// (R13) One block per erase; whole array erased block by block.
// (R14) Blocks 0-3 are 1 kbyte, 4 is 28 kbytes, 5-7 are 32 kbytes.
// (R15) In mode 2 the pin is held low and nothing is burnt or erased.
// (R16) Setup and check bit writes act only with pin high and gate 1.
// (R17) Control bit 7 reads the hardware write pin level.
// (R18) Software gate resets 0, set only while the pin is high.
// (R19) Losing pin or gate forces setup, check and run bits to 0.
`timescale 1ns/1ps
module fpec_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic hard_write_pin_i,
  input wire logic standby_i,
  input wire logic [fpec_pkg::FPEC_FA_W-1:0] erase_addr_i,
  output logic clr_setup_o,
  output logic burn_setup_o,
  output logic clr_check_o,
  output logic burn_check_o,
  output logic erase_run_o,
  output logic burn_run_o,
  output logic [7:0] block_pick_bits_o,
  output logic erase_allowed_o,
  input wire logic [fpec_pkg::FPEC_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [fpec_pkg::FPEC_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  import fpec_pkg::*;

  typedef struct packed {
    logic swg;
    logic csu;
    logic bsu;
    logic cck;
    logic bck;
    logic crun;
    logic brun;
    logic [7:0] blk;
    logic erase_ok;
    fpec_wr_e wst;
    logic [FPEC_AW-1:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fpec_st_s;

  fpec_st_s st_r;
  fpec_st_s st_nxt;
  logic rst_b;
  logic [7:0] hit;
  logic gate;
  logic do_wr;
  logic [7:0] ctl_rd;

  fpec_rst_sync u_rst (
    .clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .rst_b_o(rst_b)
  );

  fpec_blk_map u_map (
    .addr_i(erase_addr_i),
    .hit_o(hit)
  );

  assign gate = hard_write_pin_i & st_r.swg;

  // (R17) pin level on bit 7
  assign ctl_rd = {hard_write_pin_i, st_r.swg, st_r.csu, st_r.bsu, st_r.cck, st_r.bck, st_r.crun, st_r.brun};

  assign s_axil_awready = (st_r.wst == FPEC_WR_IDLE) || (st_r.wst == FPEC_WR_GOT_D);
  assign s_axil_wready = (st_r.wst == FPEC_WR_IDLE) || (st_r.wst == FPEC_WR_GOT_A);
  assign s_axil_bvalid = (st_r.wst == FPEC_WR_RESP);
  assign s_axil_bresp = st_r.bresp;
  assign s_axil_arready = !st_r.rvalid;
  assign s_axil_rvalid = st_r.rvalid;
  assign s_axil_rdata = st_r.rdata;
  assign s_axil_rresp = st_r.rresp;

  always_comb begin
    st_nxt = st_r;
    do_wr = 1'b0;
    // Write address and data are taken in either order
    case (st_r.wst)
      FPEC_WR_IDLE: begin
        if (s_axil_awvalid) begin
          st_nxt.waddr = s_axil_awaddr;
        end
        if (s_axil_wvalid) begin
          st_nxt.wbyte = s_axil_wdata[7:0];
          st_nxt.wlane = s_axil_wstrb[0];
        end
        if (s_axil_awvalid && s_axil_wvalid) begin
          st_nxt.wst = FPEC_WR_RESP;
          do_wr = 1'b1;
        end else if (s_axil_awvalid) begin
          st_nxt.wst = FPEC_WR_GOT_A;
        end else if (s_axil_wvalid) begin
          st_nxt.wst = FPEC_WR_GOT_D;
        end
      end
      FPEC_WR_GOT_A: begin
        if (s_axil_wvalid) begin
          st_nxt.wbyte = s_axil_wdata[7:0];
          st_nxt.wlane = s_axil_wstrb[0];
          st_nxt.wst = FPEC_WR_RESP;
          do_wr = 1'b1;
        end
      end
      FPEC_WR_GOT_D: begin
        if (s_axil_awvalid) begin
          st_nxt.waddr = s_axil_awaddr;
          st_nxt.wst = FPEC_WR_RESP;
          do_wr = 1'b1;
        end
      end
      FPEC_WR_RESP: begin
        if (s_axil_bready) begin
          st_nxt.wst = FPEC_WR_IDLE;
        end
      end
      default: begin
        st_nxt.wst = FPEC_WR_IDLE;
      end
    endcase

    if (do_wr) begin
      st_nxt.bresp = FPEC_RESP_OKAY;
      if (st_nxt.waddr == FPEC_OFS_CTL) begin
        if (st_nxt.wlane) begin
          // (R18) gate set needs pin high
          if (hard_write_pin_i) begin
            st_nxt.swg = st_nxt.wbyte[FPEC_CTL_SWG];
          end
          // (R01) (R02) (R03) (R16) gated setup and check writes
          if (gate) begin
            st_nxt.csu = st_nxt.wbyte[FPEC_CTL_CSU];
            st_nxt.bsu = st_nxt.wbyte[FPEC_CTL_BSU];
            st_nxt.cck = st_nxt.wbyte[FPEC_CTL_CCK];
            st_nxt.bck = st_nxt.wbyte[FPEC_CTL_BCK];
          end
          // (R04) erase run needs setup
          if (gate && st_r.csu) begin
            st_nxt.crun = st_nxt.wbyte[FPEC_CTL_CRUN];
          end
          // (R05) burn run needs setup
          if (gate && st_r.bsu) begin
            st_nxt.brun = st_nxt.wbyte[FPEC_CTL_BRUN];
          end
        end
      end else if (st_nxt.waddr == FPEC_OFS_BLK) begin
        // (R11) no block select without gate
        if (st_nxt.wlane && gate) begin
          st_nxt.blk = st_nxt.wbyte;
        end
      end else begin
        st_nxt.bresp = FPEC_RESP_SLVERR;
      end
    end

    // Read channel: one outstanding read, data held until rready
    if (st_r.rvalid) begin
      if (s_axil_rready) begin
        st_nxt.rvalid = 1'b0;
      end
    end else if (s_axil_arvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = FPEC_RESP_OKAY;
      if (s_axil_araddr == FPEC_OFS_CTL) begin
        st_nxt.rdata = {24'h000000, ctl_rd};
      end else if (s_axil_araddr == FPEC_OFS_BLK) begin
        st_nxt.rdata = {24'h000000, st_r.blk};
      end else begin
        st_nxt.rdata = FPEC_RD_UNMAPPED;
        st_nxt.rresp = FPEC_RESP_SLVERR;
      end
    end

    // (R18) gate drops with the pin
    if (!hard_write_pin_i || standby_i) begin
      st_nxt.swg = 1'b0;
    end
    // (R09) (R19) losing protection clears modes and blocks
    if (!gate || standby_i) begin
      st_nxt.csu = 1'b0;
      st_nxt.bsu = 1'b0;
      st_nxt.cck = 1'b0;
      st_nxt.bck = 1'b0;
      st_nxt.crun = 1'b0;
      st_nxt.brun = 1'b0;
      st_nxt.blk = FPEC_BLK_RST;
    end

    // (R10) only selected blocks erasable
    st_nxt.erase_ok = |(hit & st_r.blk);
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clr_setup_o = st_r.csu;
  assign burn_setup_o = st_r.bsu;
  assign clr_check_o = st_r.cck;
  assign burn_check_o = st_r.bck;
  assign erase_run_o = st_r.crun;
  assign burn_run_o = st_r.brun;
  assign block_pick_bits_o = st_r.blk;
  assign erase_allowed_o = st_r.erase_ok;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b);

  AST_BURN_SETUP_GATED: assert property ($rose(st_r.bsu) |-> $past(gate)) // (R01)
    else $error("burn setup rose without gate");
  AST_CLR_CHECK_GATED: assert property ($rose(st_r.cck) |-> $past(gate)) // (R02)
    else $error("clear check rose without gate");
  AST_BURN_CHECK_GATED: assert property ($rose(st_r.bck) |-> $past(gate)) // (R03)
    else $error("burn check rose without gate");
  AST_ERASE_RUN_SETUP: assert property ($rose(st_r.crun) |-> $past(gate && st_r.csu)) // (R04)
    else $error("erase run rose without setup");
  AST_BURN_RUN_SETUP: assert property ($rose(st_r.brun) |-> $past(gate && st_r.bsu)) // (R05)
    else $error("burn run rose without setup");
  AST_BLK_CLEARED: assert property ((!gate || standby_i) |=> st_r.blk == FPEC_BLK_RST) // (R09)
    else $error("block select not cleared");
  AST_ERASE_PERMIT: assert property (erase_allowed_o |-> $past(|(hit & st_r.blk))) // (R10)
    else $error("erase permitted on unselected block");
  AST_BLK_SET_GATE: assert property ((st_r.blk & ~$past(st_r.blk)) != 8'h00 |-> $past(st_r.swg)) // (R11)
    else $error("block select set with gate 0");
  AST_GATE_PIN: assert property ($rose(st_r.swg) |-> $past(hard_write_pin_i)) // (R18)
    else $error("gate set with pin low");
  AST_MODES_FORCED: assert property (!gate |=> !(st_r.csu || st_r.bsu || st_r.cck || st_r.bck
                                               || st_r.crun || st_r.brun)) // (R19)
    else $error("mode bits survived loss of gate");
  AST_PIN_READ: assert property (s_axil_arvalid && !st_r.rvalid && s_axil_araddr == FPEC_OFS_CTL
                                 |=> s_axil_rdata[FPEC_CTL_HWP] == $past(hard_write_pin_i)) // (R17)
    else $error("pin level misread");

  // (R02) (R03) check bits leave on 0
  AST_CLR_CHECK_LEAVE: assert property (do_wr && gate && st_nxt.wlane && st_nxt.waddr == FPEC_OFS_CTL // (R02)
                                        && !st_nxt.wbyte[FPEC_CTL_CCK] |=> !st_r.cck)
    else $error("clear check kept after write of 0");
  AST_BURN_CHECK_LEAVE: assert property (do_wr && gate && st_nxt.wlane && st_nxt.waddr == FPEC_OFS_CTL // (R03)
                                         && !st_nxt.wbyte[FPEC_CTL_BCK] |=> !st_r.bck)
    else $error("burn check kept after write of 0");

  // (R16) setup writes gated
  AST_SETUP_WRITE_GATED: assert property ($changed({st_r.csu, st_r.bsu, st_r.cck, st_r.bck}) // (R16)
                                          |-> $past(gate) || {st_r.csu, st_r.bsu, st_r.cck, st_r.bck} == 4'h0)
    else $error("setup or check bit changed without gate");

  // (R18) gate lost with pin
  AST_GATE_DROPS: assert property (!hard_write_pin_i || standby_i |=> !st_r.swg) // (R18)
    else $error("gate survived pin low or standby");

  // (R18) gate set with pin high
  AST_GATE_SET: assert property (do_wr && st_nxt.wlane && st_nxt.waddr == FPEC_OFS_CTL // (R18)
                                 && st_nxt.wbyte[FPEC_CTL_SWG] && hard_write_pin_i && !standby_i |=> st_r.swg)
    else $error("gate not set by write");

  // (R19) run bits stop
  AST_RUN_STOPS: assert property (!gate || standby_i |=> !st_r.crun && !st_r.brun) // (R19)
    else $error("run bit survived loss of protection");

  // (R09) standby clears state
  AST_STANDBY_CLEAR: assert property (standby_i |=> !st_r.swg && st_r.blk == FPEC_BLK_RST // (R09)
                                      && {st_r.csu, st_r.bsu, st_r.cck, st_r.bck, st_r.crun, st_r.brun} == 6'h00)
    else $error("standby left control state set");

  // (R14) permit inside the array
  AST_IN_ARRAY: assert property (erase_allowed_o |-> $past(erase_addr_i >= FPEC_BLK_LO[0]) // (R14)
                                 && $past(erase_addr_i <= FPEC_BLK_HI[7]))
    else $error("erase permitted outside the array");

  // (R10) (R14) unselected blocks protected
  for (genvar g = 0; g < 8; g++) begin : g_protect
    AST_BLK_PROTECT: assert property (@(posedge core_clk_i) disable iff (!rst_b) // (R10)
      erase_allowed_o && $past(erase_addr_i >= FPEC_BLK_LO[g]) && $past(erase_addr_i <= FPEC_BLK_HI[g])
      |-> $past(st_r.blk[g]))
      else $error("erase permitted on an unselected block");
  end

  // Write answer follows address and data, then stands
  AST_WR_ANSWER: assert property (do_wr |=> s_axil_bvalid)
    else $error("write not answered");
  AST_BVALID_HOLD: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped before bready");
  AST_WR_REFUSE: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write taken while response pending");
  AST_WR_UNMAPPED: assert property (do_wr && st_nxt.waddr != FPEC_OFS_CTL && st_nxt.waddr != FPEC_OFS_BLK
                                    |=> s_axil_bresp == FPEC_RESP_SLVERR)
    else $error("unmapped write not refused");

  // Read answer one cycle after the address, held until rready
  AST_RD_ANSWER: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read not answered");
  AST_RVALID_HOLD: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata)
                                    && $stable(s_axil_rresp))
    else $error("read data dropped before rready");
  AST_RD_REFUSE: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read taken while data pending");
  AST_RD_UPPER: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_RD_UNMAPPED: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr != FPEC_OFS_CTL
                                    && s_axil_araddr != FPEC_OFS_BLK
                                    |=> s_axil_rresp == FPEC_RESP_SLVERR && s_axil_rdata == FPEC_RD_UNMAPPED)
    else $error("unmapped read not refused");
endmodule

/* common/fpec_pkg.sv */
/*
  Constants for the flash program/erase control block: register map, field positions,
  reset values, bus answers and the erase block address map.
  Assumes a 32-bit AXI4-Lite register bus and an 18-bit flash array address.
*/
package fpec_pkg;
  localparam int FPEC_AW = 8;
  localparam int FPEC_FA_W = 18;
  localparam logic [7:0] FPEC_OFS_CTL = 8'h00;
  localparam logic [7:0] FPEC_OFS_BLK = 8'h04;
  localparam int FPEC_CTL_HWP = 7;
  localparam int FPEC_CTL_SWG = 6;
  localparam int FPEC_CTL_CSU = 5;
  localparam int FPEC_CTL_BSU = 4;
  localparam int FPEC_CTL_CCK = 3;
  localparam int FPEC_CTL_BCK = 2;
  localparam int FPEC_CTL_CRUN = 1;
  localparam int FPEC_CTL_BRUN = 0;
  localparam logic [7:0] FPEC_BLK_RST = 8'h00;
  localparam logic [1:0] FPEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPEC_RESP_SLVERR = 2'h2;
  localparam logic [31:0] FPEC_RD_UNMAPPED = 32'h00000000;
  // Blocks 0..3 are 1 kbyte, 4 is 28 kbytes, 5..7 are 32 kbytes each
  localparam logic [FPEC_FA_W-1:0] FPEC_BLK_LO [8] = '{18'h10000, 18'h10400, 18'h10800, 18'h10c00,
                                                      18'h11000, 18'h18000, 18'h20000, 18'h28000};
  localparam logic [FPEC_FA_W-1:0] FPEC_BLK_HI [8] = '{18'h103ff, 18'h107ff, 18'h10bff, 18'h10fff,
                                                      18'h17fff, 18'h1ffff, 18'h27fff, 18'h2ffff};
  typedef enum logic [1:0] {
    FPEC_WR_IDLE = 2'b00,
    FPEC_WR_GOT_A = 2'b01,
    FPEC_WR_RESP = 2'b11,
    FPEC_WR_GOT_D = 2'b10
  } fpec_wr_e;
endpackage

/* design/fpec_rst_sync.sv */
/*
  Reset release synchroniser: asserts asynchronously, releases after two clock edges.
  Assumes an active-low asynchronous reset input.
*/
`timescale 1ns/1ps
module fpec_rst_sync (
  input wire logic clk_i,
  input wire logic rst_b_i,
  output logic rst_b_o
);
  import fpec_pkg::*;
  logic [1:0] sync_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= {sync_r[0], 1'b1};
    end
  end

  assign rst_b_o = sync_r[1];
endmodule

/* design/fpec_blk_map.sv */
/*
  Erase block address map: one comparator pair per block gives a one-hot hit vector.
  Assumes an absolute flash array address; outside the array no block hits.
*/
`timescale 1ns/1ps
module fpec_blk_map (
  input wire logic [fpec_pkg::FPEC_FA_W-1:0] addr_i,
  output logic [7:0] hit_o
);
  import fpec_pkg::*;

  // (R14) block address ranges
  for (genvar g = 0; g < 8; g++) begin : g_blk
    assign hit_o[g] = (addr_i >= FPEC_BLK_LO[g]) && (addr_i <= FPEC_BLK_HI[g]);
  end
endmodule

/* sim/test_flash_program_erase_control.sv */
/*
  Self-checking bench for the flash program/erase control block: register accesses over
  AXI4-Lite, write gating, mode bits, block select clearing and the erase permit map.
  Assumes the design package and fpec_ctrl; one 20 MHz clock.
*/
`timescale 1ns/1ps
module test_flash_program_erase_control;
  import fpec_pkg::*;
  logic clk, rst_b, pin, stby;
  logic [17:0] ea;
  logic cs, bs, cc, bc, er, br, ok;
  logic [7:0] pick, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int errors, tests_run;
  // Block start addresses, last entry is one past the array
  logic [17:0] lo [9] = '{18'h10000, 18'h10400, 18'h10800, 18'h10c00, 18'h11000,
                          18'h18000, 18'h20000, 18'h28000, 18'h30000};

  fpec_ctrl fpec_ctrl_inst (.core_clk_i(clk), .rst_b_i(rst_b), .hard_write_pin_i(pin), .standby_i(stby),
    .erase_addr_i(ea), .clr_setup_o(cs), .burn_setup_o(bs), .clr_check_o(cc), .burn_check_o(bc),
    .erase_run_o(er), .burn_run_o(br), .block_pick_bits_o(pick), .erase_allowed_o(ok),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task conclude;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Handshakes are sampled at the falling edge, where inputs and readies are settled
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    r = 2'h1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, e}, "bresp");
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] e);
    logic ta, tb;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tb = 1'b0;
    r = 2'h1;
    d = 32'hffffffff;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tb = rvalid & rready;
      r = rresp;
      d = rdata;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, e}, "rresp");
    chk(d, exp, "rdata");
  endtask

  task ctl(input logic [7:0] d, input logic [7:0] e);
    wr(FPEC_OFS_CTL, {24'h0, d}, FPEC_RESP_OKAY);
    rd(FPEC_OFS_CTL, {24'h0, e}, FPEC_RESP_OKAY);
  endtask

  task blk(input logic [7:0] d, input logic [7:0] e);
    wr(FPEC_OFS_BLK, {24'h0, d}, FPEC_RESP_OKAY);
    rd(FPEC_OFS_BLK, {24'h0, e}, FPEC_RESP_OKAY);
  endtask

  task probe(input logic [17:0] a, input logic e);
    @(posedge clk);
    ea <= a;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, ok}, {31'h0, e}, "erase permit");
  endtask

  task pins(input logic p, input logic s);
    @(posedge clk);
    pin <= p;
    stby <= s;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    {rst_b, stby, ea, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    pin = 1'b1;
    wstrb = 4'hf;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(FPEC_OFS_CTL, 32'h80, FPEC_RESP_OKAY);
    rd(FPEC_OFS_BLK, 32'h0, FPEC_RESP_OKAY);
    ctl(8'h10, 8'h80);
    blk(8'h01, 8'h00);
    ctl(8'h40, 8'hc0);
    ctl(8'h41, 8'hc0);
    ctl(8'h50, 8'hd0);
    ctl(8'h51, 8'hd1);
    chk({26'h0, cs, bs, cc, bc, er, br}, 32'h11, "modes");
    ctl(8'h50, 8'hd0);
    ctl(8'h40, 8'hc0);
    ctl(8'h42, 8'hc0);
    ctl(8'h60, 8'he0);
    ctl(8'h62, 8'he2);
    chk({26'h0, cs, bs, cc, bc, er, br}, 32'h22, "modes");
    ctl(8'h60, 8'he0);
    ctl(8'h40, 8'hc0);
    ctl(8'h48, 8'hc8);
    chk({26'h0, cs, bs, cc, bc, er, br}, 32'h08, "modes");
    ctl(8'h40, 8'hc0);
    ctl(8'h44, 8'hc4);
    chk({26'h0, cs, bs, cc, bc, er, br}, 32'h04, "modes");
    ctl(8'h40, 8'hc0);
    // Byte lane 0 off: write has no effect
    @(posedge clk);
    wstrb <= 4'he;
    ctl(8'h50, 8'hc0);
    @(posedge clk);
    wstrb <= 4'hf;
    probe(18'h0ffff, 1'b0);
    for (int n = 0; n < 8; n++) begin
      blk(8'h01 << n, 8'h01 << n);
      chk({24'h0, pick}, 32'h1 << n, "pick");
      probe(lo[n], 1'b1);
      probe(lo[n+1] - 18'h1, 1'b1);
      probe(lo[n+1], 1'b0);
    end
    ctl(8'h00, 8'h80);
    rd(FPEC_OFS_BLK, 32'h0, FPEC_RESP_OKAY);
    ctl(8'h40, 8'hc0);
    ctl(8'h50, 8'hd0);
    blk(8'h04, 8'h04);
    pins(1'b0, 1'b0);
    chk({26'h0, cs, bs, cc, bc, er, br}, 32'h0, "modes");
    chk({24'h0, pick}, 32'h0, "pick");
    rd(FPEC_OFS_CTL, 32'h0, FPEC_RESP_OKAY);
    ctl(8'h40, 8'h00);
    pins(1'b1, 1'b0);
    ctl(8'h40, 8'hc0);
    ctl(8'h48, 8'hc8);
    blk(8'h02, 8'h02);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    rd(FPEC_OFS_BLK, 32'h0, FPEC_RESP_OKAY);
    rd(FPEC_OFS_CTL, 32'h80, FPEC_RESP_OKAY);
    // Reset during burn setup clears the mode bits and the gate
    ctl(8'h40, 8'hc0);
    ctl(8'h50, 8'hd0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({26'h0, cs, bs, cc, bc, er, br}, 32'h0, "modes");
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(FPEC_OFS_CTL, 32'h80, FPEC_RESP_OKAY);
    rd(8'h08, FPEC_RD_UNMAPPED, FPEC_RESP_SLVERR);
    wr(8'h08, 32'hff, FPEC_RESP_SLVERR);
    conclude();
  end
endmodule
